// >>> hdl/test_mux_pkg.sv
// shared constants and signal bundles for the digital test output multiplexer
package test_mux_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] REG_SELECT_B_IDX = 8'h93;
  localparam logic [7:0] REG_SELECT_C_IDX = 8'h94;
  localparam logic [11:0] ADDR_SELECT_B = {2'b00, REG_SELECT_B_IDX, 2'b00};
  localparam logic [11:0] ADDR_SELECT_C = {2'b00, REG_SELECT_C_IDX, 2'b00};

  // field layout of both select registers
  localparam int FIELD_HI_LSB = 4;
  localparam int FIELD_LO_LSB = 0;
  localparam int FIELD_W = 4;

  // reset values: every field selects the pin's normal function
  localparam logic [7:0] SELECT_B_RESET = 8'h00;
  localparam logic [7:0] SELECT_C_RESET = 8'h00;

  // selection codes with a defined meaning used by checks
  localparam logic [3:0] CODE_NORMAL = 4'h0;
  localparam logic [3:0] DATA_CLK_NVM_PUMP = 4'hF;
  localparam logic [3:0] DATA_CLK_KICK_FAILED = 4'hE;
  localparam logic [3:0] DATA_CLK_DITHER_SEQ = 4'hB;
  localparam logic [3:0] TXRX_CDR_XOR_BAUD = 4'h3;
  localparam logic [3:0] TXRX_SNIFF_B_OVF = 4'h5;
  localparam logic [3:0] RXACT_KICK_RING = 4'hB;

  // axi4-lite response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // sources observable on the data-clock pin
  typedef struct packed {
    logic nvm_pump_enable;
    logic kick_cycle_failed;
    logic rc_cal_done;
    logic energy_detect;
    logic synth_dither_sequence;
    logic precharge;
    logic pa_enable;
    logic all_id_match;
    logic manchester_clk;
    logic pattern_clk_x8;
    logic pattern_baud_clk;
    logic recovered_clk;
  } data_clk_src_t;

  // sources observable on the transmit/receive data pin
  typedef struct packed {
    logic ee_bist_bad;
    logic xtal_powerdown;
    logic buffer_done;
    logic cfg_a_sniff_overflow;
    logic code_dwell_overflow;
    logic energy_dwell_overflow;
    logic packet_timer_overflow;
    logic tx_data_encoded;
    logic pll_locked;
    logic kicker_powerdown;
    logic cfg_b_sniff_overflow;
    logic clock_recovery_data;
    logic baud_clk;
    logic fm_slice_data;
    logic recovered_data;
  } txrx_src_t;

  // sources observable on the receive-active pin
  typedef struct packed {
    logic ee_bist_done;
    logic bandgap_ready;
    logic rc_cal_fail;
    logic energy_present;
    logic kick_ring;
    logic squelch_comp;
    logic fsk_squelch_en;
    logic receive_awake;
    logic sniffer_awake;
    logic pll_reset;
    logic id_found;
    logic pll_acquire;
    logic all_pattern_match;
    logic manchester_locked;
    logic recovered_data;
    logic in_sniff;
    logic in_transmit;
  } rxact_src_t;

  // normal-function levels of the three pins
  typedef struct packed {
    logic data_clock;
    logic txrx_data;
    logic receive_active;
  } pin_normal_t;

endpackage : test_mux_pkg

// >>> hdl/axil_reg_port.sv
// axi4-lite slave front end: turns bus transfers into register strobes
`timescale 1ns/1ps
module axil_reg_port #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // read
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // register side
  output logic wr_en_o,
  output logic [ADDR_W-1:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  output logic [3:0] wr_strb_o,
  input wire logic wr_hit_i,
  output logic [ADDR_W-1:0] rd_addr_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_hit_i
);

  logic aw_have_q;
  logic w_have_q;
  logic aw_have_d;
  logic w_have_d;
  logic bvalid_d;
  logic aw_take;
  logic w_take;

  assign aw_take = s_axi_awvalid_i && s_axi_awready_o;
  assign w_take = s_axi_wvalid_i && s_axi_wready_o;
  // commit only once both halves are held, so either order works
  assign wr_en_o = aw_have_q && w_have_q && !s_axi_bvalid_o;
  assign rd_addr_o = s_axi_araddr_i;

  always_comb begin
    aw_have_d = (aw_have_q || aw_take) && !wr_en_o;
    w_have_d = (w_have_q || w_take) && !wr_en_o;
    bvalid_d = wr_en_o || (s_axi_bvalid_o && !s_axi_bready_i);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= test_mux_pkg::RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      // ready is registered, so it is low for the cycle after each take
      s_axi_awready_o <= !aw_have_d && !bvalid_d && !aw_take;
      s_axi_wready_o <= !w_have_d && !bvalid_d && !w_take;
      s_axi_bvalid_o <= bvalid_d;
      if (wr_en_o) begin
        s_axi_bresp_o <= wr_hit_i ? test_mux_pkg::RESP_OKAY : test_mux_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_addr_o <= '0;
      wr_data_o <= 32'h0000_0000;
      wr_strb_o <= 4'h0;
    end else begin
      if (aw_take) begin
        wr_addr_o <= s_axi_awaddr_i;
      end
      if (w_take) begin
        wr_data_o <= s_axi_wdata_i;
        wr_strb_o <= s_axi_wstrb_i;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= test_mux_pkg::RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= rd_hit_i ? rd_data_i : 32'h0000_0000;
        s_axi_rresp_o <= rd_hit_i ? test_mux_pkg::RESP_OKAY : test_mux_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid_o) begin
        if (s_axi_rready_i) begin
          s_axi_rvalid_o <= 1'b0;
          s_axi_arready_o <= 1'b1;
        end
      end else begin
        s_axi_arready_o <= 1'b1;
      end
    end
  end

endmodule : axil_reg_port

// >>> hdl/digital_test_output_mux.sv
// digital test output multiplexer: select registers and three observation pins
// Behaviour
// R1 - select register b holds two 4-bit fields, upper steering the data-clock pin and lower the tx/rx data pin.
// R2 - upper field code F of select register b puts the memory charge-pump enable on the data-clock pin.
// R3 - the upper field of select register b offers the failed kick cycle indication.
// R4 - the upper field of select register b offers the synthesizer dither sequence.
// R5 - lower field code 5 of select register b puts the second set's sniff timer overflow on the tx/rx data pin.
// R6 - lower field code 3 of select register b puts recovery data xor baud clock on the tx/rx data pin.
// R7 - upper field of select register c steers the receive-active pin, code 0 keeping its normal function.
// R8 - the kicker ring selection shows the squelch comparator instead whenever fsk squelch is enabled.
// R9 - codes with no listed signal drive a steady low.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
module digital_test_output_mux #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // axi4-lite register bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // internal signals offered for observation
  input wire test_mux_pkg::data_clk_src_t data_clk_src_i,
  input wire test_mux_pkg::txrx_src_t txrx_src_i,
  input wire test_mux_pkg::rxact_src_t rxact_src_i,
  input wire test_mux_pkg::pin_normal_t normal_i,
  // multipurpose pins
  output logic data_clock_pin_o,
  output logic txrx_data_pin_o,
  output logic receive_active_pin_o
);

  logic [7:0] select_b_q;
  logic [7:0] select_c_q;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [15:0] data_clk_vec;
  logic [15:0] txrx_vec;
  logic [15:0] rxact_vec;
  logic kick_or_squelch;

  // one code of a 4-bit selection field
  function automatic logic [3:0] field(input logic [7:0] r, input int lsb);
    field = r[lsb +: test_mux_pkg::FIELD_W];
  endfunction : field

  function automatic logic pick(input logic [15:0] v, input logic [3:0] code);
    pick = v[code];
  endfunction : pick

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a == ADDR_W'(test_mux_pkg::ADDR_SELECT_B)) || (a == ADDR_W'(test_mux_pkg::ADDR_SELECT_C));
  endfunction : addr_hit

  axil_reg_port #(
    .ADDR_W(ADDR_W)
  ) u_port (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i),
    .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i),
    .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i),
    .wr_en_o(wr_en),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .wr_strb_o(wr_strb),
    .wr_hit_i(wr_hit),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data),
    .rd_hit_i(rd_hit)
  );

  assign wr_hit = addr_hit(wr_addr);
  assign rd_hit = addr_hit(rd_addr);

  always_comb begin
    rd_data = 32'h0000_0000;
    if (rd_addr == ADDR_W'(test_mux_pkg::ADDR_SELECT_B)) begin
      rd_data[7:0] = select_b_q;
    end else if (rd_addr == ADDR_W'(test_mux_pkg::ADDR_SELECT_C)) begin
      rd_data[7:0] = select_c_q;
    end
  end

  // only byte lane 0 carries register bits; other lanes are ignored
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      select_b_q <= test_mux_pkg::SELECT_B_RESET;
      select_c_q <= test_mux_pkg::SELECT_C_RESET;
    end else if (wr_en && wr_strb[0]) begin
      if (wr_addr == ADDR_W'(test_mux_pkg::ADDR_SELECT_B)) begin
        select_b_q <= wr_data[7:0]; // [R1]
      end
      if (wr_addr == ADDR_W'(test_mux_pkg::ADDR_SELECT_C)) begin
        select_c_q <= wr_data[7:0]; // [R7]
      end
    end
  end

  assign kick_or_squelch = rxact_src_i.fsk_squelch_en ? rxact_src_i.squelch_comp : rxact_src_i.kick_ring; // [R8]

  // code-indexed source vectors, msb is code F; unlisted codes tied low [R9]
  assign data_clk_vec = {
    data_clk_src_i.nvm_pump_enable, // [R2]
    data_clk_src_i.kick_cycle_failed, // [R3]
    data_clk_src_i.rc_cal_done,
    data_clk_src_i.energy_detect,
    data_clk_src_i.synth_dither_sequence, // [R4]
    data_clk_src_i.precharge,
    1'b0,
    data_clk_src_i.pa_enable,
    1'b0,
    1'b0,
    data_clk_src_i.all_id_match,
    data_clk_src_i.manchester_clk,
    data_clk_src_i.pattern_clk_x8,
    data_clk_src_i.pattern_baud_clk,
    data_clk_src_i.recovered_clk,
    normal_i.data_clock
  };

  assign txrx_vec = {
    txrx_src_i.ee_bist_bad,
    txrx_src_i.xtal_powerdown,
    txrx_src_i.buffer_done,
    txrx_src_i.cfg_a_sniff_overflow,
    txrx_src_i.code_dwell_overflow,
    txrx_src_i.energy_dwell_overflow,
    txrx_src_i.packet_timer_overflow,
    txrx_src_i.tx_data_encoded,
    txrx_src_i.pll_locked,
    txrx_src_i.kicker_powerdown,
    txrx_src_i.cfg_b_sniff_overflow, // [R5]
    !txrx_src_i.clock_recovery_data,
    txrx_src_i.clock_recovery_data ^ txrx_src_i.baud_clk, // [R6]
    txrx_src_i.fm_slice_data,
    txrx_src_i.recovered_data,
    normal_i.txrx_data
  };

  assign rxact_vec = {
    rxact_src_i.ee_bist_done,
    rxact_src_i.bandgap_ready,
    rxact_src_i.rc_cal_fail,
    rxact_src_i.energy_present,
    kick_or_squelch,
    rxact_src_i.receive_awake,
    rxact_src_i.sniffer_awake,
    rxact_src_i.pll_reset,
    rxact_src_i.id_found,
    rxact_src_i.pll_acquire,
    rxact_src_i.all_pattern_match,
    rxact_src_i.manchester_locked,
    rxact_src_i.recovered_data,
    rxact_src_i.in_sniff,
    rxact_src_i.in_transmit,
    normal_i.receive_active // [R7]
  };

  // registered pins: one cycle of latency, but no glitches from the mux
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      data_clock_pin_o <= 1'b0;
      txrx_data_pin_o <= 1'b0;
      receive_active_pin_o <= 1'b0;
    end else begin
      data_clock_pin_o <= pick(data_clk_vec, field(select_b_q, test_mux_pkg::FIELD_HI_LSB)); // [R1]
      txrx_data_pin_o <= pick(txrx_vec, field(select_b_q, test_mux_pkg::FIELD_LO_LSB)); // [R1]
      receive_active_pin_o <= pick(rxact_vec, field(select_c_q, test_mux_pkg::FIELD_HI_LSB)); // [R7]
    end
  end

  a_pump_route: assert property ( // [R2]
    @(posedge core_clk_i) disable iff (rst_i)
    select_b_q[7:4] == test_mux_pkg::DATA_CLK_NVM_PUMP
      |=> data_clock_pin_o == $past(data_clk_src_i.nvm_pump_enable)
  ) else $error("data-clock pin does not show the pump enable");

  a_kick_fail: assert property ( // [R3]
    @(posedge core_clk_i) disable iff (rst_i)
    select_b_q[7:4] == test_mux_pkg::DATA_CLK_KICK_FAILED
      |=> data_clock_pin_o == $past(data_clk_src_i.kick_cycle_failed)
  ) else $error("data-clock pin does not show the failed kick");

  a_dither_seq: assert property ( // [R4]
    @(posedge core_clk_i) disable iff (rst_i)
    select_b_q[7:4] == test_mux_pkg::DATA_CLK_DITHER_SEQ
      |=> data_clock_pin_o == $past(data_clk_src_i.synth_dither_sequence)
  ) else $error("data-clock pin does not show the dither sequence");

  a_txrx_sniff_b: assert property ( // [R5]
    @(posedge core_clk_i) disable iff (rst_i)
    select_b_q[3:0] == test_mux_pkg::TXRX_SNIFF_B_OVF |=> txrx_data_pin_o == $past(txrx_src_i.cfg_b_sniff_overflow)
  ) else $error("tx/rx pin does not show the second sniff overflow");

  a_txrx_cdr_xor: assert property ( // [R6]
    @(posedge core_clk_i) disable iff (rst_i)
    select_b_q[3:0] == test_mux_pkg::TXRX_CDR_XOR_BAUD
      |=> txrx_data_pin_o == ($past(txrx_src_i.clock_recovery_data) ^ $past(txrx_src_i.baud_clk))
  ) else $error("tx/rx pin does not show recovery data xor baud clock");

  a_rxact_normal: assert property ( // [R7]
    @(posedge core_clk_i) disable iff (rst_i)
    select_c_q[7:4] == test_mux_pkg::CODE_NORMAL |=> receive_active_pin_o == $past(normal_i.receive_active)
  ) else $error("receive-active pin lost its normal function");

  a_rxact_squelch: assert property ( // [R8]
    @(posedge core_clk_i) disable iff (rst_i)
    (select_c_q[7:4] == test_mux_pkg::RXACT_KICK_RING) && rxact_src_i.fsk_squelch_en
      |=> receive_active_pin_o == $past(rxact_src_i.squelch_comp)
  ) else $error("squelch comparator not shown while squelch is enabled");

  a_unlisted_low: assert property ( // [R9]
    @(posedge core_clk_i) disable iff (rst_i)
    (select_b_q[7:4] == 4'h9) || (select_b_q[7:4] == 4'h7) || (select_b_q[7:4] == 4'h6) |=> !data_clock_pin_o
  ) else $error("unlisted data-clock code does not drive low");

  a_write_lands: assert property ( // [R1]
    @(posedge core_clk_i) disable iff (rst_i)
    wr_en && wr_strb[0] && (wr_addr == ADDR_W'(test_mux_pkg::ADDR_SELECT_B)) |=> select_b_q == $past(wr_data[7:0])
  ) else $error("write to select register b not stored");

endmodule : digital_test_output_mux

// >>> dv/pin_probe.sv
// test equipment model: samples the three multipurpose pins each rising clock edge
`timescale 1ns/1ps
module pin_probe (
  // clock
  input wire logic core_clk_i,
  // observed pins
  input wire logic data_clock_pin_i,
  input wire logic txrx_data_pin_i,
  input wire logic receive_active_pin_i,
  // last samples, data-clock pin in bit 2
  output logic [2:0] seen_o
);
  // the equipment only listens; nothing is ever driven back onto the pins
  always_ff @(posedge core_clk_i) begin
    seen_o <= {data_clock_pin_i, txrx_data_pin_i, receive_active_pin_i};
  end
endmodule : pin_probe

// >>> dv/digital_test_output_mux_tb.sv
// self-checking bench for the digital test output multiplexer
`timescale 1ns/1ps
module digital_test_output_mux_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  test_mux_pkg::data_clk_src_t dsrc = '0;
  test_mux_pkg::txrx_src_t tsrc = '0;
  test_mux_pkg::rxact_src_t xsrc = '0;
  test_mux_pkg::pin_normal_t nrm = '0;
  logic dpin, tpin, xpin;
  logic [2:0] seen;
  int bad_count = 0;
  int total_checks = 0;
  int b;
  // source bit shown by each code; -1 unlisted, -3 inverted recovery data
  int bit_map [3][16] = '{
    '{-2, 0, 1, 2, 3, 4, -1, -1, 5, -1, 6, 7, 8, 9, 10, 11},
    '{-2, 0, 1, 3, -3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14},
    '{-2, 0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 12, 13, 14, 15, 16}
  };

  always #5 core_clk = ~core_clk;

  digital_test_output_mux #(.ADDR_W(12)) digital_test_output_mux_i (
    .core_clk_i(core_clk), .rst_i(rst),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .data_clk_src_i(dsrc), .txrx_src_i(tsrc), .rxact_src_i(xsrc), .normal_i(nrm),
    .data_clock_pin_o(dpin), .txrx_data_pin_o(tpin), .receive_active_pin_o(xpin)
  );

  pin_probe pin_probe_i (
    .core_clk_i(core_clk), .data_clock_pin_i(dpin), .txrx_data_pin_i(tpin),
    .receive_active_pin_i(xpin), .seen_o(seen)
  );

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  // ready is registered, so its level at the falling edge is what the next rising edge sees
  task automatic bus_write(input logic [11:0] a, input logic [7:0] v, input logic [3:0] s, output logic [1:0] rs);
    logic ap, wp, ta, tw, got;
    ap = 1'b1;
    wp = 1'b1;
    got = 1'b0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= {24'h00_0000, v};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (ap || wp) begin
      @(negedge core_clk);
      ta = ap && awready;
      tw = wp && wready;
      @(posedge core_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      ap = ap && !ta;
      wp = wp && !tw;
    end
    bready <= 1'b1;
    while (!got) begin
      @(negedge core_clk);
      got = bvalid;
      rs = bresp;
      @(posedge core_clk);
    end
    bready <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic got;
    got = 1'b0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    while (!got) begin
      @(negedge core_clk);
      got = arready;
      @(posedge core_clk);
    end
    arvalid <= 1'b0;
    rready <= 1'b1;
    got = 1'b0;
    while (!got) begin
      @(negedge core_clk);
      got = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge core_clk);
    end
    rready <= 1'b0;
  endtask : bus_read

  task automatic set_sel(input int p, input logic [3:0] c);
    logic [1:0] rs;
    if (p == 0) bus_write(test_mux_pkg::ADDR_SELECT_B, {c, 4'h0}, 4'h1, rs);
    else if (p == 1) bus_write(test_mux_pkg::ADDR_SELECT_B, {4'h0, c}, 4'h1, rs);
    else bus_write(test_mux_pkg::ADDR_SELECT_C, {c, 4'h0}, 4'h1, rs);
  endtask : set_sel

  // one edge into the pin register, one more into the probe
  task automatic drive(input logic [16:0] v);
    @(posedge core_clk);
    dsrc <= test_mux_pkg::data_clk_src_t'(v[11:0]);
    tsrc <= test_mux_pkg::txrx_src_t'(v[14:0]);
    xsrc <= test_mux_pkg::rxact_src_t'(v);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask : drive

  task automatic check_pin(input int p, input logic e);
    check("pin", {31'h0000_0000, e}, {31'h0000_0000, seen[2-p]});
  endtask : check_pin

  initial begin
    #200000;
    bad_count++;
    finish_test();
  end

  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    bus_read(test_mux_pkg::ADDR_SELECT_B, d, r);
    check("select b reset", 32'h0000_0000, d);
    bus_read(test_mux_pkg::ADDR_SELECT_C, d, r);
    check("select c reset", 32'h0000_0000, d);
    @(posedge core_clk);
    nrm <= 3'b101;
    drive(17'h1_FFFF);
    check("normal pins", 32'h0000_0005, {29'h0000_0000, seen});
    // codes 1 to F of each pin's field: quiet sources, then only the selected one raised (all raised for unlisted codes)
    for (int p = 0; p < 3; p++) begin
      for (int c = 1; c < 16; c++) begin
        b = bit_map[p][c];
        set_sel(p, 4'(c));
        drive(17'h0_0000);
        check_pin(p, b == -3);
        drive(b >= 0 ? 17'h0_0001 << b : (b == -1 ? 17'h1_FFFF : 17'h0_0008));
        check_pin(p, b >= 0);
      end
    end
    set_sel(1, test_mux_pkg::TXRX_CDR_XOR_BAUD);
    drive(17'h0_000C);
    check_pin(1, 1'b0);
    drive(17'h0_0004);
    check_pin(1, 1'b1);
    set_sel(2, test_mux_pkg::RXACT_KICK_RING);
    drive(17'h0_1400);
    check_pin(2, 1'b0);
    drive(17'h0_0C00);
    check_pin(2, 1'b1);
    drive(17'h0_0800);
    check_pin(2, 1'b0);
    bus_write(test_mux_pkg::ADDR_SELECT_B, 8'hA5, 4'h1, r);
    check("write resp", 32'(test_mux_pkg::RESP_OKAY), 32'(r));
    bus_write(test_mux_pkg::ADDR_SELECT_B, 8'h3C, 4'h0, r);
    check("masked write resp", 32'(test_mux_pkg::RESP_OKAY), 32'(r));
    bus_read(test_mux_pkg::ADDR_SELECT_B, d, r);
    check("select b", 32'h0000_00A5, d);
    bus_write(test_mux_pkg::ADDR_SELECT_C, 8'h7E, 4'h1, r);
    bus_read(test_mux_pkg::ADDR_SELECT_C, d, r);
    check("select c", 32'h0000_007E, d);
    bus_write(12'h248, 8'hFF, 4'h1, r);
    check("unmapped write", 32'(test_mux_pkg::RESP_SLVERR), 32'(r));
    bus_read(12'h248, d, r);
    check("unmapped resp", 32'(test_mux_pkg::RESP_SLVERR), 32'(r));
    check("unmapped data", 32'h0000_0000, d);
    // reset in mid-run must bring the select back to normal
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    bus_read(test_mux_pkg::ADDR_SELECT_B, d, r);
    check("select b rereset", 32'h0000_0000, d);
    finish_test();
  end
endmodule : digital_test_output_mux_tb
